// ===== logic/mmef_monitor_flags.sv
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/100ps
// Operation
// - Receive mode code 0 to 15 sets content error, summary untouched.
// - Two contiguous command words mark the message as RT-to-RT.
// - Illegal gap inside a message sets the illegal gap flag.
// - Missing status within the selected timeout sets the timeout flag.
// - Good block set for error-free messages, cleared otherwise, at message end.
// - Busy status without transmit data is not an error.
// - Buffer pointer wrap during the message sets the rollover flag.
// - Any status bit set in a status response sets the status flag.
// - Fewer data words than the command word count sets length error.
// - No length error on busy status or on transmit timeout.
// - Wrong sync type on receive data or status word sets sync error.
// - Manchester, bit count or parity error sets invalid word flag.
// - With gap check on, RT-RT status under 4 us sets bit 2.
// - Invalid status word in RT-RT message sets bit 2.
// - RT-RT status address differing from its command sets bit 2.
// - Second RT-RT command with receive direction sets bit 1.
// - Second RT-RT command with mode subaddress sets bit 1.
// - Second RT-RT command with same address as first sets bit 1.
// - Second RT-RT command with word error sets bit 1.
// - Summary is OR of error bits and superseding, minus listed exceptions and bit 1 from mode subaddress or same address.
module mmef_monitor_flags
  import mmef_pkg::*;
#(
  parameter int TO0_NS = 18000,
  parameter int TO1_NS = 22000,
  parameter int TO2_NS = 50000,
  parameter int TO3_NS = 130000
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        sync_det_i,
  input  wire logic        word_valid_i,
  input  wire logic        word_cmd_sync_i,
  input  wire logic        word_err_i,
  input  wire logic [15:0] word_data_i,
  input  wire logic        buf_rollover_i,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [15:0] reg_rdata_o,
  output logic      [15:0] info_word_o,
  output logic             info_valid_o
);

  localparam int TO0_CYC = (TO0_NS * CLK_MHZ + 999) / 1000;
  localparam int TO1_CYC = (TO1_NS * CLK_MHZ + 999) / 1000;
  localparam int TO2_CYC = (TO2_NS * CLK_MHZ + 999) / 1000;
  localparam int TO3_CYC = (TO3_NS * CLK_MHZ + 999) / 1000;

  typedef struct packed {
    mmef_st_t    st;
    logic [15:0] gap;
    logic        in_word;
    logic [15:0] cfg;
    logic [15:0] info;
    logic        info_vld;
    logic [15:0] rd;
    logic [12:0] fl;
    logic [15:0] cmd1;
    logic [15:0] cmd2;
    logic [5:0]  wexp;
    logic [5:0]  wcnt;
    logic        tx;
    logic        bcast;
    logic        busy;
    logic        rtrt;
  } mmef_state_t;

  mmef_state_t q;
  mmef_state_t n;

  logic [15:0] to_cyc;
  logic        end_msg;
  logic        mode;
  logic        eo;
  logic [4:0]  exp_addr;

  always_comb begin
    unique case (q.cfg[CFG_TO_MSB:CFG_TO_LSB])
      2'h0: to_cyc = 16'(TO0_CYC);
      2'h1: to_cyc = 16'(TO1_CYC);
      2'h2: to_cyc = 16'(TO2_CYC);
      2'h3: to_cyc = 16'(TO3_CYC);
    endcase
  end

  always_comb begin
    n        = q;
    end_msg  = 1'b0;
    mode     = 1'b0;
    eo       = 1'b0;
    exp_addr = q.cmd1[RTA_MSB:RTA_LSB];
    n.info_vld = 1'b0;
    n.rd       = 16'h0000;

    // Register port
    if (reg_wr_i && reg_addr_i == REG_CFG) begin
      n.cfg = reg_wdata_i;
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        REG_CFG:  n.rd = q.cfg;
        REG_INFO: n.rd = q.info;
        REG_LIVE: n.rd = {3'h0, q.fl};
        default:  n.rd = 16'h0000;
      endcase
    end

    // Dead-time counter, mid-parity to next mid-sync
    if (word_valid_i) begin
      n.gap     = 16'h0000;
      n.in_word = 1'b0;
    end else if (sync_det_i) begin
      n.in_word = 1'b1;
    end else if (!q.in_word && q.gap != GAP_MAX) begin
      n.gap = q.gap + 16'h0001;
    end

    if (q.st != ST_IDLE && buf_rollover_i) begin
      n.fl[IW_ROLL] = 1'b1;
    end

    if (word_valid_i) begin
      unique case (q.st)
        ST_IDLE: begin
          if (word_cmd_sync_i && !word_err_i) begin
            n.fl    = FLAGS_CLR;
            n.cmd1  = word_data_i;
            n.wcnt  = NO_WORDS;
            n.rtrt  = 1'b0;
            n.busy  = 1'b0;
            n.tx    = word_data_i[TR_BIT];
            n.bcast = word_data_i[RTA_MSB:RTA_LSB] == BCAST_ADDR;
            mode    = word_data_i[SA_MSB:SA_LSB] == SA_MODE_LO || word_data_i[SA_MSB:SA_LSB] == SA_MODE_HI;
            if (mode) begin
              n.wexp = word_data_i[MC_DATA_BIT] ? ONE_WORD : NO_WORDS;
              if (!word_data_i[TR_BIT] && !word_data_i[MC_DATA_BIT]) begin
                n.fl[IW_COMMAND_CONTENT_ERROR] = 1'b1;
              end
            end else begin
              n.wexp = (word_data_i[WC_MSB:WC_LSB] == WC_ZERO) ? WC_FULL : {1'b0, word_data_i[WC_MSB:WC_LSB]};
            end
            if (n.bcast && n.tx) begin
              if (!mode) begin
                n.fl[IW_COMMAND_CONTENT_ERROR] = 1'b1;
                eo = 1'b1;
              end
              end_msg = 1'b1;
            end else if (!n.tx && n.wexp != NO_WORDS) begin
              n.st = ST_BCDATA;
            end else if (n.bcast) begin
              end_msg = 1'b1;
            end else begin
              n.st = ST_STAT;
            end
          end
        end
        ST_BCDATA: begin
          if (word_err_i) begin
            n.fl[IW_WE] = 1'b1;
          end
          if (word_cmd_sync_i && q.wcnt == NO_WORDS && !q.bcast) begin
            n.rtrt      = 1'b1;
            n.fl[IW_RR] = 1'b1;
            n.cmd2      = word_data_i;
            n.tx        = 1'b1;
            mode = word_data_i[SA_MSB:SA_LSB] == SA_MODE_LO || word_data_i[SA_MSB:SA_LSB] == SA_MODE_HI;
            if (!word_data_i[TR_BIT] || word_err_i) begin
              n.fl[IW_CW2] = 1'b1;
              eo = 1'b1;
            end
            if (mode || word_data_i[RTA_MSB:RTA_LSB] == q.cmd1[RTA_MSB:RTA_LSB]) begin
              n.fl[IW_CW2] = 1'b1;
            end
            n.wexp = (word_data_i[WC_MSB:WC_LSB] == WC_ZERO) ? WC_FULL : {1'b0, word_data_i[WC_MSB:WC_LSB]};
            n.st   = ST_STAT;
          end else begin
            if (word_cmd_sync_i) begin
              n.fl[IW_SE] = 1'b1;
            end
            n.wcnt = q.wcnt + ONE_WORD;
            if (n.wcnt == q.wexp) begin
              if (q.bcast) begin
                end_msg = 1'b1;
              end else begin
                n.st = ST_STAT;
              end
            end
          end
        end
        ST_STAT, ST_STAT2: begin
          if (word_err_i) begin
            n.fl[IW_WE] = 1'b1;
          end
          if (!word_cmd_sync_i) begin
            n.fl[IW_SE] = 1'b1;
          end
          if (word_data_i[STAT_FLG_MSB:0] != STAT_FLG_NONE) begin
            n.fl[IW_SFS] = 1'b1;
          end
          n.busy = word_data_i[STAT_BUSY_BIT];
          if (q.rtrt) begin
            exp_addr = (q.st == ST_STAT) ? q.cmd2[RTA_MSB:RTA_LSB] : q.cmd1[RTA_MSB:RTA_LSB];
            if (q.cfg[CFG_GAPCHK] && q.gap < 16'(STAT_MIN_CYC)) begin
              n.fl[IW_RTRT_GAP_SYNC_ADDR_ERROR] = 1'b1;
            end
            if (word_err_i || !word_cmd_sync_i) begin
              n.fl[IW_RTRT_GAP_SYNC_ADDR_ERROR] = 1'b1;
            end
            if (word_data_i[RTA_MSB:RTA_LSB] != exp_addr) begin
              n.fl[IW_RTRT_GAP_SYNC_ADDR_ERROR] = 1'b1;
            end
          end
          if (q.st == ST_STAT && q.tx && !n.busy && q.wexp != NO_WORDS) begin
            n.st = ST_RTDATA;
          end else if (q.st == ST_STAT && q.rtrt && !n.busy) begin
            n.st = ST_STAT2;
          end else begin
            end_msg = 1'b1;
          end
        end
        ST_RTDATA: begin
          if (word_err_i) begin
            n.fl[IW_WE] = 1'b1;
          end
          if (word_cmd_sync_i && !word_err_i) begin
            eo      = 1'b1;
            end_msg = 1'b1;
          end else begin
            if (word_cmd_sync_i) begin
              n.fl[IW_SE] = 1'b1;
            end
            n.wcnt = q.wcnt + ONE_WORD;
            if (n.wcnt == q.wexp) begin
              if (q.rtrt) begin
                n.st = ST_STAT2;
              end else begin
                end_msg = 1'b1;
              end
            end
          end
        end
        default: n.st = ST_IDLE;
      endcase
    end else if (!q.in_word && q.st != ST_IDLE) begin
      if ((q.st == ST_STAT || q.st == ST_STAT2) && q.gap >= to_cyc) begin
        n.fl[IW_TO] = 1'b1;
        end_msg = 1'b1;
      end else if ((q.st == ST_BCDATA || q.st == ST_RTDATA) && q.gap > 16'(CONTIG_MAX_CYC)) begin
        n.fl[IW_IGE] = 1'b1;
        if (!q.busy) begin
          n.fl[IW_LE] = 1'b1;
        end
        end_msg = 1'b1;
      end
    end

    if (end_msg) begin
      n.fl[IW_EO]  = eo || q.fl[IW_EO] || ((n.fl & EO_MASK) != FLAGS_CLR);
      n.fl[IW_GDB] = !n.fl[IW_EO];
      n.info       = {3'h0, n.fl};
      n.info_vld   = 1'b1;
      n.st         = ST_IDLE;
    end else if (eo) begin
      n.fl[IW_EO] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q.st       <= ST_IDLE;
      q.gap      <= GAP_MAX;
      q.in_word  <= 1'b0;
      q.cfg      <= CFG_RESET;
      q.info     <= 16'h0000;
      q.info_vld <= 1'b0;
      q.rd       <= 16'h0000;
      q.fl       <= FLAGS_CLR;
      q.cmd1     <= 16'h0000;
      q.cmd2     <= 16'h0000;
      q.wexp     <= NO_WORDS;
      q.wcnt     <= NO_WORDS;
      q.tx       <= 1'b0;
      q.bcast    <= 1'b0;
      q.busy     <= 1'b0;
      q.rtrt     <= 1'b0;
    end else begin
      q <= n;
    end
  end

  assign reg_rdata_o  = q.rd;
  assign info_word_o  = q.info;
  assign info_valid_o = q.info_vld;

endmodule : mmef_monitor_flags

// ===== logic/mmef_pkg.sv
package mmef_pkg;

  // Clock rate
  localparam int CLK_MHZ = 250;

  // Monitored word fields
  localparam int RTA_MSB = 15;
  localparam int RTA_LSB = 11;
  localparam int TR_BIT  = 10;
  localparam int SA_MSB  = 9;
  localparam int SA_LSB  = 5;
  localparam int WC_MSB  = 4;
  localparam int WC_LSB  = 0;
  localparam int MC_DATA_BIT   = 4;
  localparam int STAT_BUSY_BIT = 3;
  localparam int STAT_FLG_MSB  = 10;

  localparam logic [4:0]  SA_MODE_LO  = 5'h00;
  localparam logic [4:0]  SA_MODE_HI  = 5'h1F;
  localparam logic [4:0]  BCAST_ADDR  = 5'h1F;
  localparam logic [4:0]  WC_ZERO     = 5'h00;
  localparam logic [5:0]  WC_FULL     = 6'h20;
  localparam logic [5:0]  ONE_WORD    = 6'h01;
  localparam logic [5:0]  NO_WORDS    = 6'h00;
  localparam logic [10:0] STAT_FLG_NONE = 11'h000;

  // Information word bit positions
  localparam int IW_EO    = 12;
  localparam int IW_RR    = 11;
  localparam int IW_IGE   = 10;
  localparam int IW_TO    = 9;
  localparam int IW_GDB   = 8;
  localparam int IW_ROLL  = 7;
  localparam int IW_SFS   = 6;
  localparam int IW_LE    = 5;
  localparam int IW_SE    = 4;
  localparam int IW_WE    = 3;
  localparam int IW_RTRT_GAP_SYNC_ADDR_ERROR = 2;
  localparam int IW_CW2   = 1;
  localparam int IW_COMMAND_CONTENT_ERROR  = 0;
  localparam logic [12:0] FLAGS_CLR = 13'h0000;
  // Flags that feed the summary bit directly
  localparam logic [12:0] EO_MASK = 13'h063C;

  // Monitor configuration register fields
  localparam int CFG_TO_MSB = 15;
  localparam int CFG_TO_LSB = 14;
  localparam int CFG_GAPCHK = 12;
  localparam logic [15:0] CFG_RESET = 16'h0000;

  // Register port map
  localparam logic [3:0] REG_CFG  = 4'h0;
  localparam logic [3:0] REG_INFO = 4'h1;
  localparam logic [3:0] REG_LIVE = 4'h2;

  // Bus timing, from end of word (mid-parity) to next mid-sync
  localparam int STAT_MIN_NS   = 4000;
  localparam int CONTIG_MAX_NS = 3000;
  localparam int STAT_MIN_CYC   = (STAT_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int CONTIG_MAX_CYC = (CONTIG_MAX_NS * CLK_MHZ) / 1000;
  localparam logic [15:0] GAP_MAX = 16'hFFFF;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_BCDATA = 3'b001,
    ST_STAT   = 3'b011,
    ST_RTDATA = 3'b010,
    ST_STAT2  = 3'b110
  } mmef_st_t;

endpackage : mmef_pkg

// ===== verif/mmef_bus_model.sv
`timescale 1ns/100ps
module mmef_bus_model (
  input  wire logic        sys_clk_i,
  output logic             sync_det_o,
  output logic             word_valid_o,
  output logic             cmd_sync_o,
  output logic             err_o,
  output logic      [15:0] data_o,
  output logic             rollover_o
);
  initial begin
    {sync_det_o, word_valid_o, cmd_sync_o, err_o, rollover_o} = 5'h00;
    data_o = 16'h0000;
  end
  // Word after a 2 us gap; mid-parity 80 cycles after mid-sync
  task automatic send(input logic cs, input logic er, input logic [15:0] d, input logic rl);
    repeat (500) @(posedge sys_clk_i);
    sync_det_o <= 1'b1;
    @(posedge sys_clk_i);
    sync_det_o <= 1'b0;
    repeat (79) @(posedge sys_clk_i);
    {word_valid_o, cmd_sync_o, err_o, data_o, rollover_o} <= {1'b1, cs, er, d, rl};
    @(posedge sys_clk_i);
    {word_valid_o, cmd_sync_o, err_o, data_o, rollover_o} <= {1'b0, ~cs, ~er, ~d, 1'b0};
  endtask : send
endmodule : mmef_bus_model

// ===== verif/mmef_mf_properties.sv
`timescale 1ns/100ps
module mmef_mf_properties
  import mmef_pkg::*;
(
  input wire logic        sys_clk_i,
  input wire logic        rst_n_i,
  input wire logic [3:0]  reg_addr_i,
  input wire logic        reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic [15:0] info_word_o,
  input wire logic        info_valid_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  a_one_pulse: assert property (info_valid_o |=> !info_valid_o)
    else $error("info pulse too long");
  a_info_holds: assert property (!info_valid_o |-> $stable(info_word_o))
    else $error("info word moved");
  a_top_zero: assert property (info_valid_o |-> info_word_o[15:13] == 3'h0)
    else $error("info top bits set");
  a_good_vs_sum: assert property (info_valid_o |-> info_word_o[IW_GDB] != info_word_o[IW_EO])
    else $error("good block equals summary");
  a_sum_covers: assert property (info_valid_o && (info_word_o[12:0] & EO_MASK) != FLAGS_CLR
    |-> info_word_o[IW_EO])
    else $error("summary missing");
  a_to_no_len: assert property (info_valid_o && info_word_o[IW_TO] |-> !info_word_o[IW_LE])
    else $error("length error on timeout");
  a_rtrt_only: assert property (info_valid_o && (info_word_o[IW_CW2] || info_word_o[IW_RTRT_GAP_SYNC_ADDR_ERROR])
    |-> info_word_o[IW_RR])
    else $error("rt-rt error without rt-rt");
  a_rd_idle: assert property (!reg_rd_i |=> reg_rdata_o == 16'h0000)
    else $error("read data outside read");
  a_info_read: assert property (reg_rd_i && reg_addr_i == REG_INFO |=> reg_rdata_o == $past(info_word_o))
    else $error("info readback wrong");
endmodule : mmef_mf_properties

// ===== verif/testbench.sv
`timescale 1ns/100ps
module testbench;
  import mmef_pkg::*;
  logic        sys_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        sync_det_i, word_valid_i, word_cmd_sync_i, word_err_i, buf_rollover_i, info_valid_o;
  logic [15:0] word_data_i, reg_rdata_o, info_word_o, d;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic [3:0]  reg_addr_i = 4'h0;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  int          failures = 0;
  int          samples_checked = 0;

  always #2 sys_clk_i = ~sys_clk_i;

  mmef_bus_model u_bus (.sys_clk_i, .sync_det_o(sync_det_i), .word_valid_o(word_valid_i),
    .cmd_sync_o(word_cmd_sync_i), .err_o(word_err_i), .data_o(word_data_i), .rollover_o(buf_rollover_i));
  mmef_monitor_flags #(.TO0_NS(3600)) DUT (.sys_clk_i, .rst_n_i, .sync_det_i, .word_valid_i,
    .word_cmd_sync_i, .word_err_i, .word_data_i, .buf_rollover_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .info_word_o, .info_valid_o);

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic w(input logic cs, input logic er, input logic [15:0] x, input logic rl = 1'b0);
    u_bus.send(cs, er, x, rl);
  endtask : w

  task automatic msg(input string nm, input logic [15:0] e);
    int n = 0;
    #1;
    while (info_valid_o !== 1'b1 && n < 3000) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    chk(nm, e, info_word_o);
    chk("info valid", 16'h0001, {15'h0000, info_valid_o});
  endtask : msg

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] x);
    @(posedge sys_clk_i);
    {reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, x, 1'b1};
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a);
    @(posedge sys_clk_i);
    {reg_addr_i, reg_rd_i} <= {a, 1'b1};
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask : reg_rd

  task automatic m2(input logic [15:0] c, input logic [15:0] s, input logic [15:0] e);
    w(1'b1, 1'b0, c);
    w(1'b1, 1'b0, s);
    msg("two word", e);
  endtask : m2

  task automatic m3(input logic er, input logic rl, input logic [15:0] e);
    w(1'b1, 1'b0, 16'h0821);
    w(1'b0, er, 16'h1234, rl);
    w(1'b1, 1'b0, 16'h0800);
    msg("receive", e);
  endtask : m3

  task automatic rtrt(input logic [15:0] c2, input logic [15:0] s1, input logic [15:0] e);
    w(1'b1, 1'b0, 16'h0821);
    w(1'b1, 1'b0, c2);
    w(1'b1, 1'b0, s1);
    w(1'b0, 1'b0, 16'h5A5A);
    w(1'b1, 1'b0, 16'h0800);
    msg("rt-rt", e);
  endtask : rtrt

  task t_timeout();
    w(1'b1, 1'b0, 16'h0C21);
    msg("timeout", 16'h1200);
  endtask : t_timeout

  task t_short();
    w(1'b1, 1'b0, 16'h0822);
    w(1'b0, 1'b0, 16'h1111);
    msg("short", 16'h1420);
  endtask : t_short

  task t_sync();
    w(1'b1, 1'b0, 16'h0822);
    w(1'b0, 1'b0, 16'h1111);
    w(1'b1, 1'b0, 16'h2222);
    w(1'b1, 1'b0, 16'h0800);
    msg("sync", 16'h1010);
  endtask : t_sync

  task t_regs();
    reg_rd(REG_CFG);
    chk("cfg reset", CFG_RESET, d);
    reg_wr(REG_CFG, 16'hD000);
    reg_rd(REG_CFG);
    chk("cfg", 16'hD000, d);
    reg_wr(REG_INFO, 16'hFFFF);
    reg_rd(REG_INFO);
    chk("info reg", 16'h0180, d);
    reg_rd(REG_LIVE);
    chk("live flags", 16'h0180, d);
    reg_rd(4'hF);
    chk("unmapped", 16'h0000, d);
    reg_wr(REG_CFG, 16'h0000);
  endtask : t_regs

  task t_gap_chk();
    reg_wr(REG_CFG, 16'h1000);
    rtrt(16'h1421, 16'h1000, 16'h1804);
    reg_wr(REG_CFG, 16'h0000);
  endtask : t_gap_chk

  task t_rtrt_bad();
    w(1'b1, 1'b0, 16'h0821);
    w(1'b1, 1'b1, 16'h1421);
    w(1'b1, 1'b0, 16'h1000);
    w(1'b0, 1'b0, 16'h5A5A);
    w(1'b1, 1'b0, 16'h0800);
    msg("cmd2 error", 16'h180A);
    w(1'b1, 1'b0, 16'h0821);
    w(1'b1, 1'b0, 16'h1421);
    w(1'b0, 1'b0, 16'h1000);
    w(1'b0, 1'b0, 16'h5A5A);
    w(1'b1, 1'b0, 16'h0800);
    msg("status sync", 16'h1814);
  endtask : t_rtrt_bad

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (16) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    m3(1'b0, 1'b0, 16'h0100);
    m3(1'b1, 1'b0, 16'h1008);
    m3(1'b0, 1'b1, 16'h0180);
    t_regs();
    m2(16'h0801, 16'h0800, 16'h0101);
    m2(16'h0C21, 16'h0808, 16'h0140);
    t_timeout();
    t_short();
    t_sync();
    rtrt(16'h1421, 16'h1000, 16'h0900);
    rtrt(16'h0C21, 16'h0800, 16'h0902);
    rtrt(16'h1021, 16'h1000, 16'h1802);
    rtrt(16'h1421, 16'h1800, 16'h1804);
    rtrt(16'h1401, 16'h1000, 16'h0902);
    t_rtrt_bad();
    t_gap_chk();
    tally_and_finish();
  end

  initial begin
    #250000;
    failures++;
    tally_and_finish();
  end
endmodule : testbench

bind mmef_monitor_flags mmef_mf_properties u_props (.sys_clk_i, .rst_n_i, .reg_addr_i, .reg_rd_i,
  .reg_rdata_o, .info_word_o, .info_valid_o);
